// File: rtl/psc_pad_ctrl.sv
/*
  pad state control: derives the current state and drives every pad setting.
  assumes i_rst_b is the synchronised-release form of the hard reset pin and
  that core logic supplies firmware state, sensor release and pad requests.
*/
`timescale 1ns/1ns
module psc_pad_ctrl (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_standby,
  input  wire psc_pkg::psc_fw_t           i_fw_state,
  input  wire logic                       i_sensor_release,
  input  wire logic                       i_flash_sclk,
  input  wire logic                       i_flash_serial_out,
  input  wire logic                       i_flash_cs_b,
  input  wire logic                       i_flash_serial_in,
  input  wire logic                       i_sensor_clock_out,
  input  wire logic                       i_slv_sda_low,
  input  wire logic                       i_mst_scl_low,
  input  wire logic                       i_mst_sda_low,
  input  wire logic                       i_pix_frame_valid_in,
  input  wire logic                       i_pix_line_valid_in,
  input  wire logic                       i_pix_clock_in,
  input  wire logic [psc_pkg::PSC_DIN_W-1:0] i_pix_data_in,
  output psc_pkg::psc_state_t             o_state,
  output logic                            o_flash_sclk,
  output logic                            o_flash_sclk_oe_b,
  output logic                            o_flash_serial_out,
  output logic                            o_flash_serial_out_oe_b,
  output logic                            o_flash_cs_b,
  output logic                            o_flash_cs_b_oe_b,
  output logic                            o_flash_serial_in_pullup,
  output logic                            o_flash_serial_in,
  output logic                            o_sensor_clock_out,
  output logic                            o_sensor_reset_b,
  output logic                            o_slv_sda,
  output logic                            o_slv_sda_oe_b,
  output logic                            o_mst_scl,
  output logic                            o_mst_scl_oe_b,
  output logic                            o_mst_sda,
  output logic                            o_mst_sda_oe_b,
  output logic                            o_pix_frame_valid,
  output logic                            o_pix_line_valid,
  output logic                            o_pix_clock,
  output logic [psc_pkg::PSC_DIN_W-1:0]   o_pix_data
);
  import psc_pkg::*;

  localparam int unsigned SYNC_W = PSC_DIN_W + 5;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_out;
  logic              stby_s;
  logic              fin_s;
  logic              fv_s;
  logic              lv_s;
  logic              pclk_s;
  logic [PSC_DIN_W-1:0] din_s;

  // flash data idles high behind its pull-up, so its stage resets high
  psc_sync #(
    .W       (SYNC_W),
    .RST_VAL ({PSC_LVL_LOW, PSC_LVL_HIGH, PSC_LVL_LOW, PSC_LVL_LOW, PSC_LVL_LOW,
               PSC_DIN_ZERO})
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_standby, i_flash_serial_in, i_pix_frame_valid_in,
                 i_pix_line_valid_in, i_pix_clock_in, i_pix_data_in}),
    .o_sync    (sync_out)
  );

  assign {stby_s, fin_s, fv_s, lv_s, pclk_s, din_s} = sync_out;

  // ----------------------------------------------------------------
  // state code
  // ----------------------------------------------------------------
  psc_state_t next_state;

  always_comb begin
    // standby outranks whatever firmware asks for
    if (stby_s) begin
      next_state = PSC_HARD_STBY;
    end else begin
      unique case (i_fw_state)
        PSC_FW_BOOT:      next_state = PSC_DEFAULT;
        PSC_FW_SOFT_STBY: next_state = PSC_SOFT_STBY;
        PSC_FW_STREAM:    next_state = PSC_STREAM;
        PSC_FW_IDLE:      next_state = PSC_IDLE;
      endcase
    end
  end

  // reset pin forces the reset state asynchronously
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_state <= PSC_RESET;
    end else begin
      o_state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // pad selection from the next state code
  // ----------------------------------------------------------------
  // sticky: only a hard reset clears the release; the reset and default states still hold the sensor in reset
  logic released;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      released <= PSC_LVL_LOW;
    end else if (i_sensor_release) begin
      released <= PSC_LVL_HIGH;
    end
  end

  function automatic logic active(input psc_state_t s);
    active = (s == PSC_STREAM) || (s == PSC_IDLE);
  endfunction : active

  // open drain: low driver enabled only while a pull-low is requested
  function automatic logic pull_low(input logic req);
    pull_low = req ? PSC_OE_DRIVE : PSC_OE_FLOAT;
  endfunction : pull_low

  // ----------------------------------------------------------------
  // flash port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // pads float until the hard reset lets go
      o_flash_sclk             <= PSC_LVL_LOW;
      o_flash_sclk_oe_b        <= PSC_OE_FLOAT;
      o_flash_serial_out       <= PSC_LVL_LOW;
      o_flash_serial_out_oe_b  <= PSC_OE_FLOAT;
      o_flash_cs_b             <= PSC_LVL_HIGH;
      o_flash_cs_b_oe_b        <= PSC_OE_FLOAT;
      o_flash_serial_in_pullup <= PSC_LVL_HIGH;
      o_flash_serial_in        <= PSC_LVL_HIGH;
    end else begin
      o_flash_sclk_oe_b        <= PSC_OE_DRIVE;
      o_flash_serial_out_oe_b  <= PSC_OE_DRIVE;
      o_flash_cs_b_oe_b        <= PSC_OE_DRIVE;
      o_flash_serial_in_pullup <= PSC_LVL_HIGH;
      o_flash_serial_in        <= fin_s;
      if (active(next_state)) begin
        o_flash_sclk       <= i_flash_sclk;
        o_flash_serial_out <= i_flash_serial_out;
        o_flash_cs_b       <= i_flash_cs_b;
      end else begin
        o_flash_sclk       <= PSC_LVL_LOW;
        o_flash_serial_out <= PSC_LVL_LOW;
        o_flash_cs_b       <= PSC_LVL_HIGH;
      end
    end
  end

  // ----------------------------------------------------------------
  // sensor clock and reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sensor_clock_out <= PSC_LVL_LOW;
      o_sensor_reset_b   <= PSC_LVL_LOW;
    end else begin
      o_sensor_clock_out <= active(next_state) ? i_sensor_clock_out : PSC_LVL_LOW;
      unique case (next_state)
        PSC_RESET, PSC_DEFAULT: o_sensor_reset_b <= PSC_LVL_LOW;
        PSC_HARD_STBY, PSC_SOFT_STBY: o_sensor_reset_b <= released;
        PSC_STREAM, PSC_IDLE:         o_sensor_reset_b <= released;
        default:                      o_sensor_reset_b <= PSC_LVL_LOW;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // two-wire lines: open drain, float outside active states
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_slv_sda      <= PSC_LVL_LOW;
      o_slv_sda_oe_b <= PSC_OE_FLOAT;
      o_mst_scl      <= PSC_LVL_LOW;
      o_mst_scl_oe_b <= PSC_OE_FLOAT;
      o_mst_sda      <= PSC_LVL_LOW;
      o_mst_sda_oe_b <= PSC_OE_FLOAT;
    end else begin
      o_slv_sda <= PSC_LVL_LOW;
      o_mst_scl <= PSC_LVL_LOW;
      o_mst_sda <= PSC_LVL_LOW;
      if (active(next_state)) begin
        o_slv_sda_oe_b <= pull_low(i_slv_sda_low);
        o_mst_scl_oe_b <= pull_low(i_mst_scl_low);
        o_mst_sda_oe_b <= pull_low(i_mst_sda_low);
      end else begin
        o_slv_sda_oe_b <= PSC_OE_FLOAT;
        o_mst_scl_oe_b <= PSC_OE_FLOAT;
        o_mst_sda_oe_b <= PSC_OE_FLOAT;
      end
    end
  end

  // ----------------------------------------------------------------
  // pixel inputs gated to the streaming state
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pix_frame_valid <= PSC_LVL_LOW;
      o_pix_line_valid  <= PSC_LVL_LOW;
      o_pix_clock       <= PSC_LVL_LOW;
      o_pix_data        <= PSC_DIN_ZERO;
    end else if (next_state == PSC_STREAM) begin
      o_pix_frame_valid <= fv_s;
      o_pix_line_valid  <= lv_s;
      o_pix_clock       <= pclk_s;
      o_pix_data        <= din_s;
    end else begin
      o_pix_frame_valid <= PSC_LVL_LOW;
      o_pix_line_valid  <= PSC_LVL_LOW;
      o_pix_clock       <= PSC_LVL_LOW;
      o_pix_data        <= PSC_DIN_ZERO;
    end
  end

endmodule : psc_pad_ctrl

// File: rtl/psc_pkg.sv
/*
  pad state control package: state codes, pad levels and the pixel data width.
  assumes a single system clock domain and no software-visible registers.
*/
// How it works
// - flash serial data input keeps its pull-up enabled in every state.
// - sensor reset low in reset/default, high in standby once firmware released it.
// - slave data and master two-wire lines float in reset, default and standby.
// - pixel inputs used only while streaming, ignored in every other state.
package psc_pkg;

  typedef enum logic [2:0] {
    PSC_RESET,
    PSC_DEFAULT,
    PSC_HARD_STBY,
    PSC_SOFT_STBY,
    PSC_STREAM,
    PSC_IDLE
  } psc_state_t;

  // firmware state request encoding
  typedef enum logic [1:0] {
    PSC_FW_BOOT,
    PSC_FW_SOFT_STBY,
    PSC_FW_STREAM,
    PSC_FW_IDLE
  } psc_fw_t;

  localparam int unsigned PSC_DIN_W      = 12;
  localparam logic        PSC_LVL_LOW    = 1'b0;
  localparam logic        PSC_LVL_HIGH   = 1'b1;
  localparam logic        PSC_OE_DRIVE   = 1'b0;
  localparam logic        PSC_OE_FLOAT   = 1'b1;
  localparam logic [PSC_DIN_W-1:0] PSC_DIN_ZERO = 12'h000;

endpackage : psc_pkg

// File: rtl/psc_sync.sv
/*
  two-flop synchroniser for a level from outside the clock domain.
  assumes the reset is asynchronous and active low.
*/
`timescale 1ns/1ns
module psc_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta   <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : psc_sync

// File: verification/pad_state_control_bench.sv
/* bench: walks the pad controller through every state and checks its pads.
   assumes the partner model and the bound checker. */
`timescale 1ns/1ns
module pad_state_control_bench;
  import psc_pkg::*;
  // --------
  // harness
  // --------
  logic clk = 1'h0, rst_b = 1'h0, want = 1'h0, rel = 1'h0, fsi = 1'h1;
  wire stby, pclk, pull, srst, fso, sco, fvo, lvo, pco, scl;
  psc_fw_t fw = PSC_FW_BOOT;
  psc_state_t st;
  logic [3:0] core = 4'h2;
  logic [2:0] low = 3'h0;
  logic [1:0] fvl = 2'h3;
  wire [2:0] oe, dv, w;
  wire [5:0] fl;
  wire [11:0] din, pd;
  int error_cnt = 0, total_checks = 0;
  always #20 clk = !clk;
  psc_partner psc_partner_i (.i_clk_sys(clk), .i_want_stby(want), .i_oe_b(oe), .i_drv(dv),
    .o_standby(stby), .o_pclk(pclk), .o_din(din), .o_slv_scl(scl), .o_wire(w));
  psc_pad_ctrl psc_pad_ctrl_i (.i_clk_sys(clk), .i_rst_b(rst_b), .i_standby(stby),
    .i_fw_state(fw), .i_sensor_release(rel), .i_flash_sclk(core[3]),
    .i_flash_serial_out(core[2]), .i_flash_cs_b(core[1]), .i_sensor_clock_out(core[0]),
    .i_flash_serial_in(fsi), .i_slv_sda_low(low[2]), .i_mst_scl_low(low[1]),
    .i_mst_sda_low(low[0]), .i_pix_frame_valid_in(fvl[1]), .i_pix_line_valid_in(fvl[0]),
    .i_pix_clock_in(pclk), .i_pix_data_in(din), .o_state(st), .o_flash_sclk(fl[5]),
    .o_flash_sclk_oe_b(fl[4]), .o_flash_serial_out(fl[3]), .o_flash_serial_out_oe_b(fl[2]),
    .o_flash_cs_b(fl[1]), .o_flash_cs_b_oe_b(fl[0]), .o_flash_serial_in_pullup(pull),
    .o_flash_serial_in(fso), .o_sensor_clock_out(sco), .o_sensor_reset_b(srst),
    .o_slv_sda(dv[2]), .o_slv_sda_oe_b(oe[2]), .o_mst_scl(dv[1]), .o_mst_scl_oe_b(oe[1]),
    .o_mst_sda(dv[0]), .o_mst_sda_oe_b(oe[0]), .o_pix_frame_valid(fvo),
    .o_pix_line_valid(lvo), .o_pix_clock(pco), .o_pix_data(pd));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp_v);
    total_checks++;
    if (seen !== exp_v) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp_v);
    end
  endtask : chk
  task automatic look(input psc_state_t s, input logic r, input logic [5:0] f,
                      input logic [2:0] v, input logic [11:0] p, input logic [2:0] x);
    chk(12'(st), 12'(s));
    chk(12'(srst), 12'(r));
    chk(12'(pull), 12'h001);
    chk(12'(fl), 12'(f));
    chk(12'(w), 12'(v));
    chk(pd, p);
    chk(12'({fvo, lvo, sco}), 12'(x));
    if (s != PSC_STREAM) chk(12'(pco), 12'h000);
    chk(12'(scl ^ scl), 12'h000);
  endtask : look
  task automatic go(input psc_fw_t f, input logic s);
    @(posedge clk);
    fw <= f;
    want <= s;
    repeat (5) @(posedge clk);
    #1;
  endtask : go
  task automatic t_reset;
    look(PSC_RESET, 1'h0, 6'h17, 3'h7, 12'h000, 3'h0);
  endtask : t_reset
  task automatic t_default;
    @(posedge clk);
    rst_b <= 1'h1;
    rel <= 1'h1;
    low <= 3'h5;
    core <= 4'hd;
    @(posedge clk);
    rel <= 1'h0;
    go(PSC_FW_BOOT, 1'h0);
    look(PSC_DEFAULT, 1'h0, 6'h02, 3'h7, 12'h000, 3'h0);
  endtask : t_default
  task automatic t_states;
    logic px;
    go(PSC_FW_STREAM, 1'h1);
    look(PSC_HARD_STBY, 1'h1, 6'h02, 3'h7, 12'h000, 3'h0);
    go(PSC_FW_SOFT_STBY, 1'h0);
    look(PSC_SOFT_STBY, 1'h1, 6'h02, 3'h7, 12'h000, 3'h0);
    go(PSC_FW_STREAM, 1'h0);
    look(PSC_STREAM, 1'h1, 6'h28, 3'h2, 12'ha5c, 3'h7);
    px = pco;
    @(posedge clk);
    #1;
    chk(12'(pco), 12'(!px));
    @(posedge clk);
    fsi <= 1'h0;
    fvl <= 2'h2;
    repeat (3) @(posedge clk);
    #1;
    chk(12'({fso, fvo, lvo}), 12'h002);
    go(PSC_FW_IDLE, 1'h0);
    look(PSC_IDLE, 1'h1, 6'h28, 3'h2, 12'h000, 3'h1);
  endtask : t_states
  task automatic t_rereset;
    @(posedge clk);
    rst_b <= 1'h0;
    fw <= PSC_FW_BOOT;
    @(posedge clk);
    #1;
    t_reset;
    @(posedge clk);
    rst_b <= 1'h1;
    go(PSC_FW_BOOT, 1'h1);
    look(PSC_HARD_STBY, 1'h0, 6'h02, 3'h7, 12'h000, 3'h0);
  endtask : t_rereset
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    repeat (8) @(posedge clk);
    #1;
    t_reset;
    t_default;
    t_states;
    t_rereset;
    close_out;
  end
  initial begin
    #80000;
    error_cnt++;
    close_out;
  end
endmodule : pad_state_control_bench

// File: verification/psc_pad_chk.sv
/* checker: pad state relations on the pad controller ports.
   assumes one clock domain and the bind after the module. */
`timescale 1ns/1ns
module psc_pad_chk
  import psc_pkg::*;
(
  input wire logic                 i_clk_sys,
  input wire logic                 i_rst_b,
  input wire psc_pkg::psc_fw_t     i_fw_state,
  input wire psc_pkg::psc_state_t  o_state,
  input wire logic                 o_flash_serial_in_pullup,
  input wire logic                 o_sensor_reset_b,
  input wire logic                 o_slv_sda_oe_b,
  input wire logic                 o_mst_scl_oe_b,
  input wire logic                 o_mst_sda_oe_b,
  input wire logic [PSC_DIN_W-1:0] o_pix_data,
  input wire logic                 o_flash_sclk,
  input wire logic                 o_flash_sclk_oe_b,
  input wire logic                 o_flash_cs_b
);
  // -----------
  // properties
  // -----------
  wire logic all_float = o_slv_sda_oe_b && o_mst_scl_oe_b && o_mst_sda_oe_b;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  pullup_kept_a: assert property (o_flash_serial_in_pullup == 1'h1)
    else $error("flash input pull-up dropped");
  sensor_held_a: assert property (o_state == PSC_DEFAULT |-> !o_sensor_reset_b)
    else $error("sensor reset released in default");
  wires_float_a: assert property (o_state inside {PSC_STREAM, PSC_IDLE} || all_float)
    else $error("two-wire line driven outside streaming or idle");
  pix_ignored_a: assert property (o_state != PSC_STREAM |-> o_pix_data == 12'h000)
    else $error("pixel data passed outside streaming");
  stream_cause_a: assert property (
    o_state == PSC_STREAM |-> $past(i_fw_state) == PSC_FW_STREAM)
    else $error("streaming without firmware request");
  flash_parked_a: assert property (
    o_state inside {PSC_DEFAULT, PSC_HARD_STBY, PSC_SOFT_STBY}
    |-> !o_flash_sclk_oe_b && !o_flash_sclk && o_flash_cs_b)
    else $error("flash pads not parked");
  sensor_rise_a: assert property (
    $rose(o_sensor_reset_b) |-> o_state inside {PSC_HARD_STBY, PSC_SOFT_STBY, PSC_STREAM, PSC_IDLE})
    else $error("sensor reset released in reset or default");
endmodule : psc_pad_chk
bind psc_pad_ctrl psc_pad_chk psc_pad_chk_i (.i_clk_sys, .i_rst_b, .i_fw_state, .o_state,
  .o_flash_serial_in_pullup, .o_sensor_reset_b, .o_slv_sda_oe_b, .o_mst_scl_oe_b,
  .o_mst_sda_oe_b, .o_pix_data, .o_flash_sclk, .o_flash_sclk_oe_b, .o_flash_cs_b);

// File: verification/psc_partner.sv
/* partner: host standby pin, sensor pixel pins and two-wire pull-ups.
   assumes the bench chooses the standby level. */
`timescale 1ns/1ns
module psc_partner (
  input  wire logic       i_clk_sys,
  input  wire logic       i_want_stby,
  input  wire logic [2:0] i_oe_b,
  input  wire logic [2:0] i_drv,
  output logic            o_standby,
  output logic            o_pclk,
  output logic [11:0]     o_din,
  output logic            o_slv_scl,
  output logic [2:0]      o_wire
);
  // ----------
  // pin levels
  // ----------
  logic tog    = 1'h0;
  logic stby_q = 1'h0;
  always @(posedge i_clk_sys) begin
    tog    <= !tog;
    stby_q <= i_want_stby;
  end
  assign o_standby = stby_q;
  assign o_pclk    = tog;
  assign o_din     = 12'ha5c;
  // host clock always at a valid level: runs, or stops low in standby
  assign o_slv_scl = tog & !stby_q;
  // released line pulled high
  assign o_wire    = i_oe_b | i_drv;
endmodule : psc_partner
